// [readback_pkg.sv]
// Shared constants for the readback and diagnostic status block
package readback_pkg;
  localparam int word_w = 16;
  // Mode readback codes
  localparam logic [15:0] mode_code_network = 16'h0000;
  localparam logic [15:0] mode_code_external = 16'h0001;
  localparam logic [15:0] mode_code_panel = 16'h0002;
  // Mode-selection parameter values
  localparam logic [3:0] mode_sel_actual = 4'h0;
  localparam logic [3:0] mode_sel_panel_a = 4'h3;
  localparam logic [3:0] mode_sel_panel_b = 4'h4;
  // Diagnostic error numbers
  localparam logic [15:0] err_none = 16'h0000;
  localparam logic [15:0] err_missing_end = 16'h0faa;
  localparam logic [15:0] err_dup_target = 16'h0fb5;
  localparam logic [15:0] err_bad_operand = 16'h1004;
  localparam logic [15:0] err_range = 16'h1005;
  localparam logic [15:0] err_no_target = 16'h1072;
  localparam logic [15:0] err_watchdog = 16'h1389;
  localparam logic [15:0] err_scan_over = 16'h1392;
  // Number of readback channels
  localparam int chan_count = 3;
  // Fault input bit positions
  localparam int flt_missing_end = 0;
  localparam int flt_dup_target = 1;
  localparam int flt_bad_operand = 2;
  localparam int flt_range = 3;
  localparam int flt_no_target = 4;
  localparam int flt_watchdog = 5;
  localparam int flt_scan_over = 6;
  localparam int flt_count = 7;
  // Reset values
  localparam logic [15:0] word_reset = 16'h0000;
  // Run indicator blink half-period
  localparam real blink_half_ms = 250.0;
  localparam real clk_mhz = 125.0;
  localparam int blink_cycles = int'(blink_half_ms * 1000.0 * clk_mhz);
endpackage : readback_pkg

// [readback_channel.sv]
// One handshaked readback channel: edge capture, hold and completion
`timescale 1ns/1ps
`default_nettype none
module readback_channel
  import readback_pkg::*;
#(
  parameter int width = 16
)
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Request side
  input wire logic cmd,
  output logic done,
  // Data
  input wire logic [width-1:0] live_value,
  output logic [width-1:0] word
);
  // Refuse widths the capture register cannot serve
  if (width < 1 || width > 32)
  begin : g_bad_width
    $error("readback_channel: width out of range");
  end

  logic cmd_d_ff;
  logic [width-1:0] word_ff;
  logic done_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_d_ff <= 1'b0;
    else if (ce)
      cmd_d_ff <= cmd;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      word_ff <= '0;
    else if (ce && cmd && !cmd_d_ff)
      word_ff <= live_value;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      done_ff <= 1'b0;
    else if (ce)
      done_ff <= cmd && cmd_d_ff;
  end

  assign done = done_ff;
  assign word = word_ff;
endmodule : readback_channel
`default_nettype wire

// [drive_readback_and_diag_status.sv]
// Drive readback channels, diagnostic error word and error-stop control
`timescale 1ns/1ps
`default_nettype none
module drive_readback_and_diag_status
  import readback_pkg::*;
#(
  parameter int out_bits = 16,
  parameter int blink_count = blink_cycles
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Readback commands and completions
  input wire logic mode_read_cmd,
  output logic mode_read_done,
  input wire logic ram_freq_read_cmd,
  output logic ram_freq_read_done,
  input wire logic stored_freq_read_cmd,
  output logic stored_freq_read_done,
  // Drive settings
  input wire logic [15:0] actual_mode,
  input wire logic [3:0] mode_select_param,
  input wire logic speed_unit_param,
  input wire logic [15:0] ram_freq_setting,
  input wire logic [15:0] stored_freq_setting,
  // Readback words
  output logic [15:0] mode_readback_word,
  output logic [15:0] ram_frequency_readback,
  output logic [15:0] stored_frequency_readback,
  // Program fault reports, one-cycle pulses
  input wire logic [flt_count-1:0] fault_pulse,
  // Sequence outputs and error stop
  input wire logic [out_bits-1:0] program_outputs,
  input wire logic hard_clear_input,
  output logic [out_bits-1:0] output_devices,
  output logic error_stop,
  output logic [15:0] diag_error_word,
  output logic run_indicator
);
  // Refuse sizes the logic cannot serve
  if (out_bits < 1 || blink_count < 1)
  begin : g_bad_param
    $error("drive_readback_and_diag_status: bad parameter");
  end

  logic [15:0] mode_live;
  logic [chan_count-1:0] ch_cmd;
  logic [chan_count-1:0][15:0] ch_live;
  wire [chan_count-1:0] ch_done;
  wire [chan_count-1:0][15:0] ch_word;
  logic [15:0] nxt_err;
  logic [15:0] diag_ff;
  logic stop_ff;
  logic [out_bits-1:0] out_ff;
  logic [31:0] blink_cnt_ff;
  logic blink_ff;
  logic [2:0] clr_sync_ff;

  always_comb
  begin
    if (mode_select_param == mode_sel_panel_a || mode_select_param == mode_sel_panel_b)
      mode_live = mode_code_panel;
    else
      mode_live = actual_mode;
  end

  // Channel 0 mode, 1 RAM frequency, 2 stored frequency
  assign ch_cmd = {stored_freq_read_cmd, ram_freq_read_cmd, mode_read_cmd};

  // stored setting in its own units
  // speed unit chosen upstream by speed_unit_param
  assign ch_live = {stored_freq_setting, ram_freq_setting, mode_live};

  for (genvar g = 0; g < chan_count; g++)
  begin : g_chan
    readback_channel #(.width(16)) u_readback_channel (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .cmd(ch_cmd[g]),
      .done(ch_done[g]),
      .live_value(ch_live[g]),
      .word(ch_word[g])
    );
  end

  assign mode_read_done = ch_done[0];
  assign ram_freq_read_done = ch_done[1];
  assign stored_freq_read_done = ch_done[2];
  assign mode_readback_word = ch_word[0];
  assign ram_frequency_readback = ch_word[1];
  assign stored_frequency_readback = ch_word[2];

  // Hard clear comes from a pin
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      clr_sync_ff <= 3'b000;
    else if (ce)
      clr_sync_ff <= {clr_sync_ff[1:0], hard_clear_input};
  end

  // Priority encode of fault reports, lowest number first
  always_comb
  begin
    nxt_err = err_none;
    if (fault_pulse[flt_scan_over])
      nxt_err = err_scan_over;
    if (fault_pulse[flt_watchdog])
      nxt_err = err_watchdog;
    if (fault_pulse[flt_no_target])
      nxt_err = err_no_target;
    if (fault_pulse[flt_range])
      nxt_err = err_range;
    if (fault_pulse[flt_bad_operand])
      nxt_err = err_bad_operand;
    if (fault_pulse[flt_dup_target])
      nxt_err = err_dup_target;
    if (fault_pulse[flt_missing_end])
      nxt_err = err_missing_end;
  end

  // cleared only by hard clear or reset, set wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      diag_ff <= word_reset;
    else if (ce)
    begin
      // A fault in the clear cycle keeps the stop, so it keeps its word
      if (nxt_err != err_none && !stop_ff)
        diag_ff <= nxt_err;
      else if (clr_sync_ff[1] && clr_sync_ff[2] && nxt_err == err_none)
        diag_ff <= word_reset;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stop_ff <= 1'b0;
    else if (ce)
    begin
      if (nxt_err != err_none)
        stop_ff <= 1'b1;
      else if (clr_sync_ff[1] && clr_sync_ff[2])
        stop_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      out_ff <= '0;
    else if (ce)
    begin
      if (stop_ff || nxt_err != err_none)
        out_ff <= '0;
      else
        out_ff <= program_outputs;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blink_cnt_ff <= 32'h0;
      blink_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (!stop_ff)
      begin
        blink_cnt_ff <= 32'h0;
        blink_ff <= 1'b0;
      end
      else if (blink_cnt_ff >= 32'(blink_count - 1))
      begin
        blink_cnt_ff <= 32'h0;
        blink_ff <= !blink_ff;
      end
      else
        blink_cnt_ff <= blink_cnt_ff + 32'h1;
    end
  end

  assign output_devices = out_ff;
  assign error_stop = stop_ff;
  assign diag_error_word = diag_ff;
  assign run_indicator = stop_ff ? blink_ff : 1'b1;
endmodule : drive_readback_and_diag_status
`default_nettype wire

// [readback_properties.sv]
// Checker for readback handshake and error stop
`timescale 1ns/1ps
`default_nettype none
module readback_properties
  import readback_pkg::*;
#(
  parameter int out_bits = 16
)
(
  // Clock, reset and mode channel
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mode_read_cmd,
  input wire logic mode_read_done,
  input wire logic [3:0] mode_select_param,
  input wire logic [15:0] actual_mode,
  input wire logic [15:0] mode_readback_word,
  // Error stop
  input wire logic [flt_count-1:0] fault_pulse,
  input wire logic [out_bits-1:0] output_devices,
  input wire logic error_stop,
  input wire logic [15:0] diag_error_word
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_done_rise: assert property ($rose(mode_read_cmd)
    |-> ##1 !mode_read_done ##1 mode_read_done) else $error("done late");
  a_mode_code: assert property ($rose(mode_read_cmd) |=> mode_readback_word ==
    ($past(mode_select_param) inside {4'h3, 4'h4} ? 16'h0002 : $past(actual_mode)))
    else $error("mode code");
  a_word_hold: assert property (mode_read_cmd [*3] |-> $stable(mode_readback_word))
    else $error("word moved");
  a_done_drop: assert property ($fell(mode_read_cmd) |=> !mode_read_done)
    else $error("done stuck");
  a_stop_entry: assert property (|fault_pulse |=> error_stop)
    else $error("no stop");
  a_outs_zero: assert property (error_stop |-> output_devices == '0)
    else $error("outputs live");
  a_first_code: assert property (fault_pulse[0] && !error_stop |=>
    diag_error_word == err_missing_end) else $error("code wrong");
  a_code_kept: assert property (error_stop [*2] |-> $stable(diag_error_word))
    else $error("code moved");
  c_panel: cover property (mode_read_done && mode_select_param == 4'h4);
  c_stop: cover property ($rose(error_stop));
  c_clear: cover property ($fell(error_stop));
endmodule : readback_properties
bind drive_readback_and_diag_status readback_properties #(.out_bits(out_bits))
  u_readback_properties (.*);
`default_nettype wire

// [seq_requester.sv]
// Sequence program model raising the three readback commands
`timescale 1ns/1ps
`default_nettype none
module seq_requester
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control and handshake
  input wire logic [2:0] go,
  input wire logic [2:0] hold,
  output logic [2:0] cmd,
  input wire logic [2:0] done
);
  // new edge only once idle, release after done
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmd <= 3'h0;
    else
      for (int c = 0; c < 3; c++)
        if (!cmd[c] && !done[c] && go[c])
          cmd[c] <= 1'b1;
        else if (cmd[c] && done[c] && !hold[c])
          cmd[c] <= 1'b0;
  end
endmodule : seq_requester
`default_nettype wire

// [tb_top.sv]
// Bench for readback channels, diagnostic word and error stop
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, hc = 1'b0;
  logic [2:0] go = '0, hold = '0;
  logic [3:0] sel = '0;
  logic [6:0] flt = '0;
  logic [15:0] act = '0, ram = '0, sto = '0, po = '0;
  wire es, ri;
  logic rb = 1'b0;
  wire [2:0] cmd, done;
  wire [15:0] od, dw;
  wire [15:0] w [3];
  logic [15:0] codes [7] = '{16'h0faa, 16'h0fb5, 16'h1004, 16'h1005, 16'h1072, 16'h1389, 16'h1392};
  int err_count = 0, cmp_count = 0;
  initial forever #4 clk = ~clk;
  drive_readback_and_diag_status #(.blink_count(4)) u_drive_readback_and_diag_status (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .mode_read_cmd(cmd[0]),
    .mode_read_done(done[0]), .ram_freq_read_cmd(cmd[1]), .ram_freq_read_done(done[1]),
    .stored_freq_read_cmd(cmd[2]), .stored_freq_read_done(done[2]), .actual_mode(act),
    .mode_select_param(sel), .speed_unit_param(1'b0), .ram_freq_setting(ram),
    .stored_freq_setting(sto), .mode_readback_word(w[0]), .ram_frequency_readback(w[1]),
    .stored_frequency_readback(w[2]), .fault_pulse(flt), .program_outputs(po),
    .hard_clear_input(hc), .output_devices(od), .error_stop(es), .diag_error_word(dw),
    .run_indicator(ri));
  seq_requester u_seq_requester (.clk(clk), .rst_n(rst_n), .go(go), .hold(hold),
    .cmd(cmd), .done(done));
  task automatic conclude();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic tick(int k);
    repeat (k) @(posedge clk);
  endtask : tick
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Wait for completion high, or for the channel to go idle
  task automatic wt(int c, logic up);
    int i;
    for (i = 0; i < 20 && (up ? done[c] : cmd[c] | done[c]) !== up; i++)
      tick(1);
    if (i == 20)
    begin
      err_count++;
      conclude();
    end
  endtask : wt
  task automatic rd(int c, logic [15:0] e, logic h);
    go <= 3'(1 << c);
    tick(1);
    go <= '0;
    wt(c, 1'b1);
    chk("word", e, w[c]);
    if (!h)
      wt(c, 1'b0);
  endtask : rd
  initial
  begin
    tick(20);
    rst_n <= 1'b1;
    for (int m = 0; m < 12; m++)
    begin
      act <= 16'(m % 3);
      sel <= 4'(m / 3 * 3 % 5);
      rd(0, (m / 3) % 2 ? 16'h0002 : 16'(m % 3), 1'b0);
    end
    ram <= 16'h1770;
    sto <= 16'h04d2;
    rd(1, 16'h1770, 1'b0);
    hold[1] <= 1'b1;
    rd(1, 16'h1770, 1'b1);
    ram <= 16'h1b58;
    tick(4);
    chk("held", 16'h1770, w[1]);
    hold[1] <= 1'b0;
    wt(1, 1'b0);
    rd(1, 16'h1b58, 1'b0);
    rd(2, 16'h04d2, 1'b0);
    po <= 16'h5a5a;
    chk("steady", 16'h0001, 16'(ri));
    for (int f = 0; f < 7; f++)
    begin
      flt <= 7'(3 << f);
      tick(1);
      flt <= f ? 7'h01 : 7'h02;
      tick(1);
      flt <= 7'h00;
      tick(2);
      chk("code", codes[f], dw);
      chk("stopped", 16'h0000, od);
      chk("kept", 16'h04d2, w[2]);
      rb = ri;
      hc <= 1'b1;
      tick(4);
      chk("blink", 16'(!rb), 16'(ri));
      tick(1);
      hc <= 1'b0;
      tick(3);
      chk("cleared", 16'h0000, dw);
      chk("resumed", 16'h5a5a, od);
    end
    // Power loss during a stop also leaves it
    flt <= 7'h10;
    tick(1);
    flt <= 7'h00;
    tick(2);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    chk("reset stop", 16'h0000, 16'(es));
    chk("reset code", 16'h0000, dw);
    rd(2, 16'h04d2, 1'b0);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
